// File: core/cmp_pkg.sv
// shared constants, modes and carriers of the compare and measure block
package cmp_pkg;
    // time base of the block
    localparam int          CLK_HZ       = 125_000_000;
    localparam int          US_PER_S     = 1_000_000;
    localparam int          CYC_PER_US   = CLK_HZ / US_PER_S;
    localparam int          US_PER_DUR   = 100;            // pulse duration unit 0.1 ms
    localparam logic [15:0] PULSE_DUR_RST = 16'h1388;      // 500.0 ms
    localparam logic [24:0] UPD_TIME_RST  = 25'h0002710;   // 10.000 ms in us
    localparam logic [31:0] CMP0_RST      = 32'h00000000;
    localparam logic [31:0] CMP1_INT_RST  = 32'h0000000a;  // 10
    localparam logic [31:0] CMP1_REAL_RST = 32'h41200000;  // 10.0
    localparam logic [7:0]  HYST_RST      = 8'h00;
    // velocity time bases in us
    localparam logic [63:0] TB_1MS_US   = 64'h00000000000003e8;
    localparam logic [63:0] TB_10MS_US  = 64'h0000000000002710;
    localparam logic [63:0] TB_100MS_US = 64'h00000000000186a0;
    localparam logic [63:0] TB_1S_US    = 64'h00000000000f4240;
    localparam logic [63:0] TB_60S_US   = 64'h0000000003938700;
    localparam logic [31:0] SIGN_BIT    = 32'h80000000;

    typedef enum logic {MODE_COUNT = 1'b0, MODE_MEASURE = 1'b1} mode_t;
    typedef enum logic [1:0] {DIR_BOTH = 2'b00, DIR_UP = 2'b01, DIR_DOWN = 2'b10} dir_t;
    // output functions in counting mode
    typedef enum logic [2:0] {
        FN_CMP_HIGH  = 3'b000,
        FN_CMP_LOW   = 3'b001,
        FN_WINDOW    = 3'b010,
        FN_PULSE     = 3'b011,
        FN_SET_UNTIL = 3'b100,
        FN_USER      = 3'b101
    } fn_t;
    // output functions in measurement mode
    typedef enum logic [2:0] {
        MF_GE          = 3'b000,
        MF_LE          = 3'b001,
        MF_BETWEEN     = 3'b010,
        MF_NOT_BETWEEN = 3'b011,
        MF_USER        = 3'b101
    } mfn_t;
    typedef enum logic [1:0] {VAR_FREQ = 2'b00, VAR_PERIOD = 2'b01, VAR_VEL = 2'b10} var_t;
    typedef enum logic [2:0] {
        TB_1MS = 3'b000, TB_10MS = 3'b001, TB_100MS = 3'b010, TB_1S = 3'b011, TB_60S = 3'b100
    } tb_t;

    // count event from the counter core
    typedef struct packed {
        logic               pulse;   // one count pulse this cycle
        logic               up;      // direction of that pulse
        logic               load;    // counter loaded, e.g. synchronisation
        logic signed [31:0] value;   // counter value after this cycle's event
    } cnt_evt_t;

    // per-output configuration
    typedef struct packed {
        logic [2:0]  fn;   // fn_t or mfn_t, by mode
        dir_t        dir;
        logic [31:0] cmp;  // integer or float bits, by mode
    } out_cfg_t;
endpackage

// File: core/tick_gen.sv
// one-cycle enable pulse every DIV clocks
`timescale 1ns/1ps
`default_nettype none
module tick_gen #(
    parameter int DIV = 125
) (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic rst_in,
    // enable pulse
    output logic      tick_out
);
    logic [15:0] cnt_q;

    // free-running divider
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cnt_q    <= 16'h0000;
            tick_out <= 1'b0;
        end else begin
            tick_out <= (cnt_q == 16'(DIV - 1));
            cnt_q    <= (cnt_q == 16'(DIV - 1)) ? 16'h0000 : cnt_q + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// File: core/seq_divider.sv
// serial restoring divider, one quotient bit per clock
`timescale 1ns/1ps
`default_nettype none
module seq_divider #(
    parameter int W = 64
) (
    // clock and reset
    input  wire logic         clk_in,
    input  wire logic         rst_in,
    // request
    input  wire logic         start_in,
    input  wire logic [W-1:0] num_in,
    input  wire logic [W-1:0] den_in,
    // answer
    output logic              busy_out,
    output logic              done_out,
    output logic [W-1:0]      quot_out
);
    logic [W-1:0] rem_q;
    logic [W-1:0] den_q;
    logic [7:0]   cnt_q;
    logic [W:0]   rsh;
    logic [W:0]   sub;

    // trial subtraction
    always_comb begin
        rsh = {rem_q, quot_out[W-1]};
        sub = rsh - {1'b0, den_q};
    end

    // shift and subtract loop
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rem_q    <= '0;
            den_q    <= '0;
            quot_out <= '0;
            cnt_q    <= 8'h00;
            busy_out <= 1'b0;
            done_out <= 1'b0;
        end else begin
            done_out <= 1'b0;
            if (start_in && !busy_out) begin
                rem_q    <= '0;
                den_q    <= den_in;
                quot_out <= num_in;
                cnt_q    <= 8'(W);
                busy_out <= 1'b1;
            end else if (busy_out) begin
                rem_q    <= sub[W] ? rsh[W-1:0] : sub[W-1:0];
                quot_out <= {quot_out[W-2:0], ~sub[W]};
                cnt_q    <= cnt_q - 8'h01;
                busy_out <= (cnt_q != 8'h01);
                done_out <= (cnt_q == 8'h01);
            end
        end
    end
endmodule
`default_nettype wire

// File: core/counter_compare_and_measure.sv
// compare outputs and measured value of a counting channel
`timescale 1ns/1ps
`default_nettype none
module counter_compare_and_measure
    import cmp_pkg::*;
#(
    parameter bit HAS_OUT0 = 1'b1
) (
    // clock and reset
    input  wire logic               clk_in,
    input  wire logic               rst_in,
    // counter core
    input  wire cnt_evt_t           cnt_in,
    input  wire logic signed [31:0] low_limit_in,
    input  wire logic signed [31:0] high_limit_in,
    // configuration
    input  wire mode_t              mode_in,
    input  wire out_cfg_t           cfg0_in,
    input  wire out_cfg_t           cfg1_in,
    input  wire logic [7:0]         hyst_in,
    input  wire logic [15:0]        pulse_dur_in,
    input  wire var_t               meas_var_in,
    input  wire logic [24:0]        upd_time_in,
    input  wire tb_t                time_base_in,
    input  wire logic [15:0]        incr_per_unit_in,
    // controller commands
    input  wire logic [1:0]         set_cmd_in,
    input  wire logic [1:0]         user_val_in,
    // outputs and feedback
    output logic                    compare_output_zero_out,
    output logic                    compare_output_one_out,
    output logic                    output_zero_status_flag_out,
    output logic [31:0]             measured_value_out,
    output logic                    measured_upd_out
);
    out_cfg_t           cfg [2];
    logic [1:0]         out_q, out_d, lock_q, raw, band_hit, hit, frozen, tmr_end;
    logic [22:0]        tmr_q [2];
    logic [22:0]        dur_us;
    logic               us_tick;
    logic signed [31:0] v;
    logic [31:0]        tot_q, meas_real_q;
    logic signed [31:0] net_q;
    logic [24:0]        win_q;
    logic               win_end, div_go_q, div_busy, div_done, neg_q, neg_s_q;
    logic [63:0]        num_q, den_q, quot;
    var_t               var_q;

    assign cfg[0] = cfg0_in;
    assign cfg[1] = cfg1_in;
    assign v      = cnt_in.value;
    assign dur_us = 23'(32'(pulse_dur_in) * US_PER_DUR);

    // direction qualifier
    function automatic logic dir_ok(dir_t d, logic up);
        return (d == DIR_BOTH) || (d == DIR_UP && up) || (d == DIR_DOWN && !up);
    endfunction

    // value inside band around c, cut at the counting limits
    function automatic logic in_band(logic signed [31:0] x, logic signed [31:0] c,
                                     logic signed [31:0] lo, logic signed [31:0] hi,
                                     logic [7:0] h);
        logic signed [32:0] bl, bh, hs;
        hs = {25'h0, h};
        bl = c - hs;
        bh = c + hs;
        if (bl < lo) bl = lo;
        if (bh > hi) bh = hi;
        return (x >= bl) && (x <= bh);
    endfunction

    // float bits to an unsigned-ordered key
    function automatic logic [31:0] fkey(logic [31:0] f);
        return f[31] ? ~f : (f | SIGN_BIT);
    endfunction

    // unsigned magnitude with sign to float, truncating
    function automatic logic [31:0] to_real(logic neg, logic [63:0] m);
        logic [31:0] r;
        logic [63:0] sh;
        logic [6:0]  p;
        r = 32'h00000000;
        p = 7'h00;
        for (int k = 0; k < 64; k++) begin
            if (m[k]) p = 7'(k);
        end
        if (m != 64'h0) begin
            sh = m << (7'd63 - p);
            r  = {neg, 8'(8'd127 + 8'(p)), sh[62:40]};
        end
        return r;
    endfunction

    // time base in microseconds
    function automatic logic [63:0] tb_us(tb_t t);
        logic [63:0] r;
        r = TB_60S_US;
        unique case (t)
            TB_1MS:   r = TB_1MS_US;
            TB_10MS:  r = TB_10MS_US;
            TB_100MS: r = TB_100MS_US;
            TB_1S:    r = TB_1S_US;
            TB_60S:   r = TB_60S_US;
            default:  r = TB_60S_US;
        endcase
        return r;
    endfunction

    tick_gen #(.DIV(CYC_PER_US)) u_tick (
        .clk_in   (clk_in),
        .rst_in   (rst_in),
        .tick_out (us_tick)
    );

    // raw conditions, hysteresis bands and count hits per output
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            raw[i]      = 1'b0;
            band_hit[i] = 1'b0;
            unique case (cfg[i].fn)
                FN_CMP_HIGH: begin
                    raw[i]      = ($signed(cfg[i].cmp) <= v) && (v <= high_limit_in);
                    band_hit[i] = in_band(v, high_limit_in, low_limit_in, high_limit_in, hyst_in);
                end
                FN_CMP_LOW: begin
                    raw[i]      = (low_limit_in <= v) && (v <= $signed(cfg[i].cmp));
                    band_hit[i] = in_band(v, low_limit_in, low_limit_in, high_limit_in, hyst_in);
                end
                FN_WINDOW: begin
                    raw[i]      = (i == 1) && ($signed(cfg[0].cmp) <= v) && (v <= $signed(cfg[1].cmp));
                    band_hit[i] = in_band(v, $signed(cfg[0].cmp), low_limit_in, high_limit_in, hyst_in);
                end
                default: ;
            endcase
            band_hit[i] = (hyst_in != HYST_RST) && (mode_in == MODE_COUNT)
                && (band_hit[i] || in_band(v, $signed(cfg[i].cmp), low_limit_in, high_limit_in, hyst_in));
            frozen[i]  = lock_q[i] && band_hit[i];
            hit[i]     = cnt_in.pulse && !cnt_in.load && dir_ok(cfg[i].dir, cnt_in.up)
                && (v == $signed(cfg[i].cmp)) && !frozen[i];
            tmr_end[i] = us_tick && (tmr_q[i] == 23'h000001);
        end
    end

    // next output level by mode and function
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            out_d[i] = out_q[i];
            if (mode_in == MODE_MEASURE) begin
                unique case (cfg[i].fn)
                    MF_GE:          out_d[i] = fkey(meas_real_q) >= fkey(cfg[i].cmp);
                    MF_LE:          out_d[i] = fkey(meas_real_q) <= fkey(cfg[i].cmp);
                    MF_BETWEEN:     out_d[i] = (i == 1) && fkey(cfg[0].cmp) <= fkey(meas_real_q)
                                               && fkey(meas_real_q) <= fkey(cfg[1].cmp);
                    MF_NOT_BETWEEN: out_d[i] = (i == 1) && fkey(cfg[1].cmp) <= fkey(meas_real_q)
                                               && fkey(meas_real_q) <= fkey(cfg[0].cmp);
                    MF_USER:        out_d[i] = user_val_in[i];
                    default:        out_d[i] = 1'b0;
                endcase
            end else begin
                unique case (cfg[i].fn)
                    FN_CMP_HIGH, FN_CMP_LOW: begin
                        if (!frozen[i]) out_d[i] = raw[i];
                    end
                    FN_WINDOW: begin
                        if (i == 0) out_d[i] = 1'b0;
                        else if (cnt_in.pulse && dir_ok(cfg[i].dir, cnt_in.up) && !frozen[i])
                            out_d[i] = raw[i];
                    end
                    FN_PULSE: begin
                        if (hit[i]) out_d[i] = 1'b1;
                        else if (pulse_dur_in == 16'h0000 && cnt_in.pulse) out_d[i] = 1'b0;
                        else if (pulse_dur_in != 16'h0000 && tmr_end[i]) out_d[i] = 1'b0;
                    end
                    FN_SET_UNTIL: begin
                        if (hit[i]) out_d[i] = 1'b0;
                        else if (set_cmd_in[i]) out_d[i] = 1'b1;
                    end
                    FN_USER: out_d[i] = user_val_in[i];
                    default: out_d[i] = 1'b0;
                endcase
            end
        end
    end

    // output flops, physical pin zero only where it exists
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            out_q                       <= 2'b00;
            compare_output_zero_out     <= 1'b0;
            compare_output_one_out      <= 1'b0;
            output_zero_status_flag_out <= 1'b0;
        end else begin
            out_q                       <= out_d;
            compare_output_zero_out     <= HAS_OUT0 && out_d[0];
            compare_output_one_out      <= out_d[1];
            output_zero_status_flag_out <= out_d[0];
        end
    end

    // hysteresis lock: a switch arms it, leaving the band releases it
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            lock_q <= 2'b00;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (out_d[i] != out_q[i] && hyst_in != HYST_RST && mode_in == MODE_COUNT)
                    lock_q[i] <= 1'b1;
                else if (!band_hit[i])
                    lock_q[i] <= 1'b0;
            end
        end
    end

    // pulse timers in microseconds
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            tmr_q[0] <= 23'h000000;
            tmr_q[1] <= 23'h000000;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (hit[i]) tmr_q[i] <= dur_us;
                else if (us_tick && tmr_q[i] != 23'h000000) tmr_q[i] <= tmr_q[i] - 23'h000001;
            end
        end
    end

    // update window; zero interval closes it every microsecond
    assign win_end = us_tick && (upd_time_in == 25'h0 || win_q + 25'h1 >= upd_time_in);

    // increment gathering and divider set-up at window end
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            tot_q    <= 32'h00000000;
            net_q    <= 32'sh00000000;
            win_q    <= 25'h0000000;
            div_go_q <= 1'b0;
            num_q    <= 64'h0;
            den_q    <= 64'h0;
            neg_q    <= 1'b0;
            var_q    <= VAR_FREQ;
        end else begin
            div_go_q <= 1'b0;
            if (win_end) begin
                tot_q <= {31'h0, cnt_in.pulse};
                net_q <= cnt_in.pulse ? (cnt_in.up ? 32'sh1 : -32'sh1) : 32'sh0;
                win_q <= 25'h0000000;
                var_q <= meas_var_in;
                neg_q <= 1'b0;
                unique case (meas_var_in)
                    VAR_PERIOD: begin
                        num_q    <= 64'(win_q) + 64'h1;
                        den_q    <= 64'(tot_q);
                        div_go_q <= (tot_q != 32'h0);
                    end
                    VAR_VEL: begin
                        num_q    <= 64'(net_q[31] ? -net_q : net_q) * tb_us(time_base_in);
                        den_q    <= (64'(win_q) + 64'h1) * 64'(incr_per_unit_in);
                        neg_q    <= net_q[31];
                        div_go_q <= (incr_per_unit_in != 16'h0);
                    end
                    default: begin
                        num_q    <= 64'(tot_q) * 64'(US_PER_S);
                        den_q    <= 64'(win_q) + 64'h1;
                        div_go_q <= 1'b1;
                    end
                endcase
            end else begin
                if (us_tick) win_q <= win_q + 25'h1;
                if (cnt_in.pulse) begin
                    tot_q <= tot_q + 32'h1;
                    net_q <= cnt_in.up ? net_q + 32'sh1 : net_q - 32'sh1;
                end
            end
        end
    end

    seq_divider #(.W(64)) u_div (
        .clk_in   (clk_in),
        .rst_in   (rst_in),
        .start_in (div_go_q),
        .num_in   (num_q),
        .den_in   (den_q),
        .busy_out (div_busy),
        .done_out (div_done),
        .quot_out (quot)
    );

    // measured value field and compare operand
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            measured_value_out <= 32'h00000000;
            meas_real_q        <= 32'h00000000;
            measured_upd_out   <= 1'b0;
            neg_s_q            <= 1'b0;
        end else begin
            measured_upd_out <= div_done;
            if (div_go_q) neg_s_q <= neg_q;
            if (div_done) begin
                meas_real_q        <= to_real(neg_s_q, quot);
                measured_value_out <= (var_q == VAR_PERIOD) ? quot[31:0] : to_real(neg_s_q, quot);
            end
        end
    end

    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);

    a_pulse_fires: assert property (
        mode_in == MODE_COUNT && cfg[1].fn == FN_PULSE && hit[1] |=> out_q[1] && compare_output_one_out)
        else $error("pulse not started at comparison value");
    a_zero_dur_hold: assert property (
        mode_in == MODE_COUNT && cfg[1].fn == FN_PULSE && pulse_dur_in == 16'h0000 && out_q[1]
        && !cnt_in.pulse |=> out_q[1])
        else $error("zero duration pulse dropped without count");
    a_dir_filter: assert property (
        mode_in == MODE_COUNT && cfg[1].fn == FN_PULSE && cfg[1].dir == DIR_UP && cnt_in.pulse
        && !cnt_in.up && !out_q[1] |=> !compare_output_one_out)
        else $error("pulse fired against selected direction");
    a_high_level: assert property (
        mode_in == MODE_COUNT && cfg[0].fn == FN_CMP_HIGH && hyst_in == 8'h00
        |=> output_zero_status_flag_out
            == ($signed($past(cfg[0].cmp)) <= $past(v) && $past(v) <= $past(high_limit_in)))
        else $error("high window level wrong");
    a_meas_ge: assert property (
        mode_in == MODE_MEASURE && cfg[0].fn == MF_GE
        |=> output_zero_status_flag_out == (fkey($past(meas_real_q)) >= fkey($past(cfg[0].cmp))))
        else $error("measurement compare level wrong");
    a_load_quiet: assert property (
        mode_in == MODE_COUNT && cfg[1].fn == FN_PULSE && cnt_in.load && !out_q[1] |=> !out_q[1])
        else $error("pulse fired on counter load");
    a_hyst_freeze: assert property (
        mode_in == MODE_COUNT && cfg[0].fn == FN_CMP_HIGH && lock_q[0] && band_hit[0] |=> $stable(out_q[0]))
        else $error("output switched inside hysteresis band");
    a_zero_upd_tick: assert property (
        upd_time_in == 25'h0 && us_tick |-> win_end ##1 (div_go_q || meas_var_in != VAR_FREQ || $past(meas_var_in) != VAR_FREQ))
        else $error("zero update time did not refresh");
    a_div_result: assert property (
        div_done |=> measured_upd_out ##0 (var_q != VAR_PERIOD || measured_value_out == $past(quot[31:0])))
        else $error("measured value not presented");
endmodule
`default_nettype wire

// File: verif/enc_model.sv
// encoder pulse source, one up count every PER clocks
`timescale 1ns/1ps
`default_nettype none
module enc_model
    import cmp_pkg::*;
#(
    parameter int PER = 125
) (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic rst_in,
    // pulse enable
    input  wire logic en_in,
    // count event
    output var cnt_evt_t evt_out
);
    int div_q;
    // periodic pulse, counter value steps by one on each pulse
    always @(negedge clk_in) begin
        evt_out.pulse <= 1'b0;
        if (rst_in) begin
            div_q         <= 0;
            evt_out.up    <= 1'b1;
            evt_out.load  <= 1'b0;
            evt_out.value <= '0;
        end else if (en_in) begin
            div_q <= (div_q == PER - 1) ? 0 : div_q + 1;
            if (div_q == PER - 1) begin
                evt_out.pulse <= 1'b1;
                evt_out.value <= evt_out.value + 1;
            end
        end
    end
endmodule
`default_nettype wire

// File: verif/test_counter_compare_and_measure.sv
// self-checking bench of the compare and measure block
`timescale 1ns/1ps
`default_nettype none
module test_counter_compare_and_measure;
    import cmp_pkg::*;
    logic               clk_in = 1'b0;
    logic               rst_in = 1'b1;
    logic               enc_en = 1'b0;
    cnt_evt_t           drv_evt = '0;
    cnt_evt_t           enc_evt;
    mode_t              mode = MODE_COUNT;
    out_cfg_t           cfg0 = '0;
    out_cfg_t           cfg1 = '0;
    var_t               mvar = VAR_FREQ;
    tb_t                tbase = TB_1MS;
    logic signed [31:0] low = 0;
    logic signed [31:0] high = 1000;
    logic [7:0]         hyst = 8'h00;
    logic [15:0]        dur = 16'h0000;
    logic [24:0]        upd_t = 25'h0000014;
    logic [15:0]        ipu = 16'h0008;
    logic [1:0]         cmd = 2'h0;
    logic [1:0]         uval = 2'h0;
    logic               o0, o1, fl, upd;
    logic [31:0]        mval;
    logic [2:0]         out_q[$];
    logic [31:0]        meas_q[$];
    logic [31:0]        mexp[3] = '{32'h49742400, 32'h00000001, 32'h42fa0000};
    logic               e1 = 1'b0, lk = 1'b0, e0p = 1'b0;
    int                 c1, n_fail = 0, n_compared = 0;

    always #4 clk_in = ~clk_in;

    enc_model #(.PER(125)) partner (.clk_in(clk_in), .rst_in(rst_in), .en_in(enc_en), .evt_out(enc_evt));

    counter_compare_and_measure #(.HAS_OUT0(1'b1)) dut (
        .clk_in(clk_in), .rst_in(rst_in), .cnt_in(enc_en ? enc_evt : drv_evt),
        .low_limit_in(low), .high_limit_in(high), .mode_in(mode), .cfg0_in(cfg0), .cfg1_in(cfg1),
        .hyst_in(hyst), .pulse_dur_in(dur), .meas_var_in(mvar), .upd_time_in(upd_t),
        .time_base_in(tbase), .incr_per_unit_in(ipu), .set_cmd_in(cmd), .user_val_in(uval),
        .compare_output_zero_out(o0), .compare_output_one_out(o1),
        .output_zero_status_flag_out(fl), .measured_value_out(mval), .measured_upd_out(upd));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // one count event, expectation noted for the next edge
    task automatic step(input int v, input logic p, input logic u, input logic l);
        logic e0;
        logic bd;
        int   h;
        @(negedge clk_in);
        drv_evt = '{p, u, l, v};
        h = hyst;
        if (p && u && !l && v == c1) e1 = 1'b1;
        else if (p) e1 = 1'b0;
        bd = (h != 0) && ((v >= 5 - h && v <= 5 + h) || (v >= 1000 - h && v <= 1000));
        e0 = (lk && bd) ? e0p : ((v >= 5) && (v <= 1000));
        lk = (e0 != e0p && h != 0) || (lk && bd);
        e0p = e0;
        out_q.push_back({e0, e1, e0});
    endtask

    task automatic wait_upd();
        int k;
        k = 0;
        do begin
            @(posedge clk_in);
            #1;
            k++;
        end while (upd !== 1'b1 && k < 4000);
        if (k >= 4000) n_fail++;
    endtask

    // monitor takes the oldest note whenever a result is due
    always @(posedge clk_in) begin
        #1;
        if (out_q.size() > 0) chk({29'h0, o0, o1, fl}, {29'h0, out_q.pop_front()});
        if (upd === 1'b1 && meas_q.size() > 0) chk(mval, meas_q.pop_front());
    end

    // watchdog against a hang
    initial begin
        #400_000;
        n_fail++;
        summarize();
    end

    initial begin
        void'($urandom(32'h6ee0));
        c1 = 20 + ($urandom % 50);
        cfg0 = '{FN_CMP_HIGH, DIR_BOTH, 32'h00000005};
        cfg1 = '{FN_PULSE, DIR_UP, c1};
        repeat (10) @(negedge clk_in);
        rst_in = 1'b0;
        @(negedge clk_in);
        chk({29'h0, o0, o1, fl}, 32'h0);
        chk(mval, 32'h0);
        for (int v = 0; v <= c1 + 1; v++) step(v, 1'b1, 1'b1, 1'b0);
        step(c1, 1'b0, 1'b1, 1'b1);
        step(c1, 1'b1, 1'b0, 1'b0);
        step(c1, 1'b1, 1'b1, 1'b0);
        step(c1, 1'b0, 1'b1, 1'b0);
        step(c1 + 1, 1'b1, 1'b1, 1'b0);
        step(1001, 1'b0, 1'b1, 1'b1);
        step(1000, 1'b1, 1'b0, 1'b0);
        @(negedge clk_in);
        hyst = 8'h03;
        step(4, 1'b1, 1'b0, 1'b0);
        step(5, 1'b1, 1'b1, 1'b0);
        step(9, 1'b1, 1'b1, 1'b0);
        step(4, 1'b1, 1'b0, 1'b0);
        step(1, 1'b1, 1'b0, 1'b0);
        @(negedge clk_in);
        mode = MODE_MEASURE;
        cfg0 = '{MF_GE, DIR_BOTH, 32'h42c80000}; // 100.0
        cfg1 = '{MF_BETWEEN, DIR_BOTH, 32'h43480000}; // 200.0
        enc_en = 1'b1;
        for (int i = 0; i < 3; i++) begin
            @(negedge clk_in);
            mvar = var_t'(i);
            wait_upd();
            wait_upd();
            @(negedge clk_in);
            meas_q.push_back(mexp[i]);
            wait_upd();
        end
        repeat (4) @(negedge clk_in);
        chk({29'h0, o0, o1, fl}, 32'h00000007);
        // zero update time refreshes every microsecond
        upd_t = 25'h0000000;
        tbase = TB_10MS;
        wait_upd();
        wait_upd();
        @(negedge clk_in);
        meas_q.push_back(32'h449c4000); // 1250.0
        wait_upd();
        repeat (2) @(negedge clk_in);
        chk(meas_q.size(), 32'h0);
        summarize();
    end
endmodule
`default_nettype wire
